// [common/bfe_pkg.sv]
package bfe_pkg;

   // Configuration word layout
   localparam int CFG_W          = 16;
   localparam int G1_LSB         = 0;
   localparam int G1_W           = 2;
   localparam int G2_LSB         = 2;
   localparam int G2_W           = 3;
   localparam int POL_BIT        = 5;
   localparam int RES_LSB        = 6;
   localparam int RES_W          = 4;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // Resolution range in bits
   localparam logic [4:0] RES_MIN = 5'h0A;
   localparam logic [4:0] RES_MAX = 5'h10;

   // Gains in tenths
   localparam logic [8:0] G1_X10_00 = 9'h078;
   localparam logic [8:0] G1_X10_01 = 9'h0C8;
   localparam logic [8:0] G1_X10_10 = 9'h12C;
   localparam logic [8:0] G1_X10_11 = 9'h190;
   localparam logic [4:0] G2_X10_BASE = 5'h0B;

   // Minimum settle length of each measurement phase in clocks
   localparam logic [7:0] PHASE_CYC = 8'h10;

   // Amplifier input sources
   typedef enum logic [1:0] {
      BFE_SRC_BRIDGE = 2'h0,
      BFE_SRC_TEMP   = 2'h1,
      BFE_SRC_SHORT  = 2'h2
   } bfe_src_e;

   typedef enum logic [1:0] {
      BFE_MODE_CYCLE = 2'h0,
      BFE_MODE_CMD   = 2'h1
   } bfe_mode_e;

   // Front-end settings held during a measurement
   typedef struct packed {
      logic [8:0] g1_x10;
      logic [4:0] g2_x10;
      logic       invert;
      logic [4:0] res_bits;
   } bfe_gain_s;

   // Analog control bundle
   typedef struct packed {
      bfe_src_e   src;
      logic       autozero;
      logic       convert;
      logic       chop_inv;
   } bfe_ana_s;

endpackage

// [design/bfe_gain_decode.sv]
`timescale 1ns/1ps
module bfe_gain_decode
   import bfe_pkg::*;
(
   // Configuration in
   input  wire logic [CFG_W-1:0] cfg_word,
   // Decoded settings out
   output bfe_gain_s             gain
);

   function automatic logic [8:0] g1_decode(input logic [1:0] sel);
      case (sel)
         2'h0:    g1_decode = G1_X10_00;
         2'h1:    g1_decode = G1_X10_01;
         2'h2:    g1_decode = G1_X10_10;
         default: g1_decode = G1_X10_11;
      endcase
   endfunction

   wire logic [G1_W-1:0]  first_stage_gain_sel;
   wire logic [G2_W-1:0]  second_stage_gain_sel;
   wire logic [RES_W-1:0] res_code;
   wire logic [4:0]       res_raw;

   assign first_stage_gain_sel  = cfg_word[G1_LSB +: G1_W];
   assign second_stage_gain_sel = cfg_word[G2_LSB +: G2_W];
   assign res_code              = cfg_word[RES_LSB +: RES_W];
   assign res_raw               = RES_MIN + {1'b0, res_code};
   assign gain.g1_x10   = g1_decode(first_stage_gain_sel);
   assign gain.g2_x10   = G2_X10_BASE + {2'h0, second_stage_gain_sel};
   assign gain.invert   = cfg_word[POL_BIT];
   assign gain.res_bits = (res_raw > RES_MAX) ? RES_MAX : res_raw;

endmodule

// [design/bfe_front_end_ctrl.sv]
`timescale 1ns/1ps
module bfe_front_end_ctrl
   import bfe_pkg::*;
(
   // Clock and supervisor reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // Serial interface side
   input  wire logic             cfg_wr,
   input  wire logic [CFG_W-1:0] cfg_wdata,
   input  wire logic             cmd_mode,
   input  wire logic             meas_req,
   input  wire logic             wake_tick,
   output logic [CFG_W-1:0]      front_end_config_word,
   output logic                  busy_ff,
   output logic                  done_ff,
   // Converter side
   input  wire logic             conv_done,
   input  wire logic [15:0]      conv_data,
   // Analog controls
   output bfe_ana_s              ana_ff,
   output bfe_gain_s             gain_ff,
   output logic                  sleep_ff,
   // Results for correction math
   output logic [15:0]           bridge_raw_ff,
   output logic [15:0]           temp_raw_ff,
   output logic [15:0]           offset_comb_ff
);

   typedef enum logic [6:0] {
      ST_SLEEP = 7'h01,
      ST_AZB   = 7'h02,
      ST_BRG   = 7'h04,
      ST_AZT   = 7'h08,
      ST_TMP   = 7'h10,
      ST_OFS   = 7'h20,
      ST_DONE  = 7'h40
   } bfe_state_e;

   bfe_state_e  state_ff;
   bfe_state_e  nxt_state;
   logic [CFG_W-1:0] cfg_ff;
   logic [15:0] az_br_ff;
   logic [15:0] az_tm_ff;
   logic [7:0]  settle_ff;
   bfe_gain_s   gain_dec;
   bfe_mode_e   mode;

   wire logic   start;
   wire logic   step_done;
   wire logic   in_meas;

   bfe_gain_decode u_dec (
      .cfg_word (cfg_ff),
      .gain     (gain_dec)
   );

   assign mode      = cmd_mode ? BFE_MODE_CMD : BFE_MODE_CYCLE;
   assign start     = (state_ff == ST_SLEEP) &&
                      ((mode == BFE_MODE_CYCLE) ? wake_tick : meas_req);
   assign in_meas   = (state_ff != ST_SLEEP) && (state_ff != ST_DONE);
   assign step_done = in_meas && (settle_ff == PHASE_CYC) && conv_done;
   assign front_end_config_word = cfg_ff;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ff <= CFG_RESET;
      end else if (cfg_wr) begin
         cfg_ff <= cfg_wdata;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SLEEP: if (start) nxt_state = ST_AZB;
         ST_AZB:   if (step_done) nxt_state = ST_BRG;
         ST_BRG:   if (step_done) nxt_state = ST_AZT;
         ST_AZT:   if (step_done) nxt_state = ST_TMP;
         ST_TMP:   if (step_done) nxt_state = ST_OFS;
         ST_OFS:   if (step_done) nxt_state = ST_DONE;
         ST_DONE:  nxt_state = ST_SLEEP;
         default:  nxt_state = ST_SLEEP;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_SLEEP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Settle count per phase
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_ff <= 8'h00;
      end else if (!in_meas || step_done) begin
         settle_ff <= 8'h00;
      end else if (settle_ff != PHASE_CYC) begin
         settle_ff <= settle_ff + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gain_ff <= '0;
      end else if (start) begin
         gain_ff <= gain_dec;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ana_ff <= '{src: BFE_SRC_BRIDGE, autozero: 1'b0, convert: 1'b0, chop_inv: 1'b0};
      end else begin
         case (nxt_state)
            ST_AZB:  ana_ff <= '{src: BFE_SRC_BRIDGE, autozero: 1'b1, convert: 1'b1,
                                 chop_inv: start ? gain_dec.invert : gain_ff.invert};
            ST_BRG:  ana_ff <= '{src: BFE_SRC_BRIDGE, autozero: 1'b0, convert: 1'b1,
                                 chop_inv: gain_ff.invert};
            ST_AZT:  ana_ff <= '{src: BFE_SRC_TEMP, autozero: 1'b1, convert: 1'b1, chop_inv: 1'b0};
            ST_TMP:  ana_ff <= '{src: BFE_SRC_TEMP, autozero: 1'b0, convert: 1'b1, chop_inv: 1'b0};
            ST_OFS:  ana_ff <= '{src: BFE_SRC_SHORT, autozero: 1'b0, convert: 1'b1, chop_inv: 1'b0};
            default: ana_ff <= '{src: BFE_SRC_BRIDGE, autozero: 1'b0, convert: 1'b0, chop_inv: 1'b0};
         endcase
      end
   end

   // Capture converter results
   // offset minus bridge auto-zero
   // raw values handed to correction math
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         az_br_ff       <= 16'h0000;
         az_tm_ff       <= 16'h0000;
         bridge_raw_ff  <= 16'h0000;
         temp_raw_ff    <= 16'h0000;
         offset_comb_ff <= 16'h0000;
      end else if (step_done) begin
         case (state_ff)
            ST_AZB:  az_br_ff <= conv_data;
            ST_BRG:  bridge_raw_ff <= conv_data - az_br_ff;
            ST_AZT:  az_tm_ff <= conv_data;
            ST_TMP:  temp_raw_ff <= conv_data - az_tm_ff;
            ST_OFS:  offset_comb_ff <= conv_data - az_br_ff;
            default: az_br_ff <= az_br_ff;
         endcase
      end
   end

   // Status and sleep
   // return to sleep
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
         sleep_ff <= 1'b1;
      end else begin
         busy_ff  <= (nxt_state != ST_SLEEP) && (nxt_state != ST_DONE);
         done_ff  <= (nxt_state == ST_DONE);
         sleep_ff <= (nxt_state == ST_SLEEP);
      end
   end

   property p_az_before_bridge;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(state_ff == ST_BRG) |-> $past(state_ff) == ST_AZB;
   endproperty
   a_az_before_bridge: assert property (p_az_before_bridge) else $error("bridge without auto-zero");

   property p_az_before_temp;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(state_ff == ST_TMP) |-> $past(state_ff) == ST_AZT;
   endproperty
   a_az_before_temp: assert property (p_az_before_temp) else $error("temperature without auto-zero");

   property p_mux_temp;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == ST_TMP) |-> ana_ff.src == BFE_SRC_TEMP;
   endproperty
   a_mux_temp: assert property (p_mux_temp) else $error("temperature source wrong");

   property p_mux_short;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == ST_OFS) |-> ana_ff.src == BFE_SRC_SHORT;
   endproperty
   a_mux_short: assert property (p_mux_short) else $error("offset source wrong");

   sequence s_ofs_end;
      (state_ff == ST_OFS) && step_done;
   endsequence
   property p_back_to_sleep;
      @(posedge ref_clk) disable iff (sys_rst)
      s_ofs_end |=> (state_ff == ST_DONE) ##1 (state_ff == ST_SLEEP) && sleep_ff;
   endproperty
   a_back_to_sleep: assert property (p_back_to_sleep) else $error("no return to sleep");

   property p_gain_held;
      @(posedge ref_clk) disable iff (sys_rst)
      in_meas && !start |=> $stable(gain_ff);
   endproperty
   a_gain_held: assert property (p_gain_held) else $error("gain changed mid measurement");

   property p_chop_pol;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == ST_AZB || state_ff == ST_BRG) |-> ana_ff.chop_inv == gain_ff.invert;
   endproperty
   a_chop_pol: assert property (p_chop_pol) else $error("chopper polarity wrong");

   property p_cycle_wake;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == ST_SLEEP) && !cmd_mode && wake_tick |=> (state_ff == ST_AZB) && busy_ff;
   endproperty
   a_cycle_wake: assert property (p_cycle_wake) else $error("cycle mode did not wake");

   property p_res_range;
      @(posedge ref_clk) disable iff (sys_rst)
      start |=> (gain_ff.res_bits >= RES_MIN) && (gain_ff.res_bits <= RES_MAX);
   endproperty
   a_res_range: assert property (p_res_range) else $error("resolution out of range");

   property p_res_max;
      @(posedge ref_clk) disable iff (sys_rst)
      gain_ff.res_bits <= RES_MAX;
   endproperty
   a_res_max: assert property (p_res_max) else $error("resolution above maximum");

endmodule

// [tb/bfe_conv_model.sv]
`timescale 1ns/1ps
// Converter and sensor stand-in: one result per period while busy
module bfe_conv_model
   import bfe_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Sequencer view
   input  wire logic        busy,
   input  bfe_ana_s         ana,
   input  wire logic [7:0]  period,
   // Converter result
   output logic             conv_done,
   output logic [15:0]      conv_data
);
   bfe_ana_s    last_ff;
   logic [7:0]  cnt_ff;
   logic [15:0] val;
   logic        phase_new;
   logic        fire;

   assign val = (ana.src == BFE_SRC_TEMP) ? (ana.autozero ? 16'h0020 : 16'h0800) :
                (ana.src == BFE_SRC_SHORT) ? 16'h0100 : (ana.autozero ? 16'h0010 : 16'h1000);
   assign phase_new = !busy || (ana.src != last_ff.src) || (ana.autozero != last_ff.autozero);
   assign fire = !phase_new && (cnt_ff == period - 8'h01);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_ff   <= '0;
         cnt_ff    <= 8'h00;
         conv_done <= 1'b0;
         conv_data <= 16'hFFFF;
      end else begin
         last_ff   <= ana;
         cnt_ff    <= (phase_new || fire) ? 8'h00 : cnt_ff + 8'h01;
         conv_done <= fire;
         // Off-strobe data is inverted so stale values never match
         conv_data <= fire ? val : ~val;
      end
   end
endmodule

// [tb/tb_bfe_front_end_ctrl.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_bfe_front_end_ctrl
   import bfe_pkg::*;
;
   logic        ref_clk, sys_rst, cfg_wr, cmd_mode, meas_req, wake_tick, busy_ff, done_ff, sleep_ff, conv_done;
   logic [15:0] cfg_wdata, front_end_config_word, conv_data, bridge_raw_ff, temp_raw_ff, offset_comb_ff;
   logic [7:0]  period;
   bfe_ana_s    ana_ff;
   bfe_gain_s   gain_ff, gsnap, gend;
   logic [14:0] seq;
   logic        chop_seen, conv_off;
   int          mismatches, n_tests, cyc;

   bfe_front_end_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cmd_mode(cmd_mode), .meas_req(meas_req), .wake_tick(wake_tick),
      .front_end_config_word(front_end_config_word), .busy_ff(busy_ff), .done_ff(done_ff),
      .conv_done(conv_done), .conv_data(conv_data), .ana_ff(ana_ff), .gain_ff(gain_ff), .sleep_ff(sleep_ff),
      .bridge_raw_ff(bridge_raw_ff), .temp_raw_ff(temp_raw_ff), .offset_comb_ff(offset_comb_ff));
   bfe_conv_model u_conv (.ref_clk(ref_clk), .sys_rst(sys_rst), .busy(busy_ff), .ana(ana_ff),
      .period(period), .conv_done(conv_done), .conv_data(conv_data));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic wcfg(input logic [15:0] d);
      @(posedge ref_clk);
      cfg_wr    <= 1'b1;
      cfg_wdata <= d;
      @(posedge ref_clk);
      cfg_wr    <= 1'b0;
   endtask

   // One full measurement, recording phase order and held settings
   task automatic run(input logic use_cmd);
      int n;
      logic [2:0] cur;
      seq = '0;
      conv_off = 1'b0;
      cur = 3'h7;
      n = 0;
      @(posedge ref_clk);
      if (use_cmd) meas_req <= 1'b1;
      else wake_tick <= 1'b1;
      @(posedge ref_clk);
      meas_req  <= 1'b0;
      wake_tick <= 1'b0;
      while (done_ff !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
         if (busy_ff === 1'b1) begin
            if (cur == 3'h7) gsnap = gain_ff;
            gend = gain_ff;
            if (ana_ff.convert !== 1'b1) conv_off = 1'b1;
            if ({ana_ff.src, ana_ff.autozero} !== cur) begin
               cur = {ana_ff.src, ana_ff.autozero};
               seq = {seq[11:0], cur};
            end
            if (ana_ff.src == BFE_SRC_BRIDGE && !ana_ff.autozero) chop_seen = ana_ff.chop_inv;
         end
      end
      `CHK("timeout", 1'b1, done_ff) // run completes
      @(negedge ref_clk);
      `CHK("sleep", 1'b1, sleep_ff) // back to sleep
      `CHK("phases", 15'b001_000_011_010_100, seq) // phase order
      `CHK("bridge", 16'h0FF0, bridge_raw_ff) // bridge minus zero
      `CHK("temp", 16'h07E0, temp_raw_ff) // temp minus zero
      `CHK("offset", 16'h00F0, offset_comb_ff) // offset combine
      `CHK("held", gsnap, gend) // settings held
      `CHK("convert", 1'b0, conv_off) // converter run each phase
   endtask

   logic [8:0] g1_tab [4] = '{9'h078, 9'h0C8, 9'h12C, 9'h190};
   logic [3:0] i4;
   initial begin
      {sys_rst, cfg_wr, cmd_mode, meas_req, wake_tick} = 5'b10100;
      cfg_wdata = 16'h0000;
      period = 8'h14;
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      `CHK("rst sleep", 1'b1, sleep_ff) // reset state
      `CHK("rst busy", 1'b0, busy_ff) // reset state
      `CHK("rst cfg", 16'h0000, front_end_config_word) // reset state
      for (int i = 0; i < 8; i++) begin
         i4 = i[3:0];
         @(posedge ref_clk);
         cmd_mode <= i4[0];
         period   <= (i < 4) ? 8'h14 : 8'h05;
         wcfg({6'h00, i4, i4[0], i4[2:0], i4[1:0]});
         run(i4[0]); // both modes
         `CHK("cfg", {6'h00, i4, i4[0], i4[2:0], i4[1:0]}, front_end_config_word) // word kept
         `CHK("g1", g1_tab[i4[1:0]], gsnap.g1_x10) // stage one gain
         `CHK("g2", 5'h0B + {2'h0, i4[2:0]}, gsnap.g2_x10) // stage two gain
         `CHK("pol", i4[0], gsnap.invert) // polarity bit
         `CHK("chop", i4[0], chop_seen) // chopper inverted
         `CHK("res", (i < 7) ? 5'h0A + {1'b0, i4} : 5'h10, gsnap.res_bits) // resolution range
      end
      // Config write and extra request while measuring
      fork
         run(1'b1);
         begin
            repeat (30) @(posedge ref_clk);
            cfg_wr    <= 1'b1;
            cfg_wdata <= 16'h003F;
            meas_req  <= 1'b1;
            @(posedge ref_clk);
            cfg_wr    <= 1'b0;
            meas_req  <= 1'b0;
         end
      join
      `CHK("cfg new", 16'h003F, front_end_config_word) // word updated
      repeat (10) @(negedge ref_clk);
      `CHK("no restart", 1'b0, busy_ff) // busy request refused
      // Wrong start source for each mode
      @(posedge ref_clk);
      cmd_mode <= 1'b0;
      meas_req <= 1'b1;
      @(posedge ref_clk);
      meas_req <= 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHK("cycle idle", 1'b0, busy_ff) // cycle mode start
      @(posedge ref_clk);
      cmd_mode  <= 1'b1;
      wake_tick <= 1'b1;
      @(posedge ref_clk);
      wake_tick <= 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHK("cmd idle", 1'b0, busy_ff) // command mode start
      // Supervisor reset in mid-measurement
      @(posedge ref_clk);
      meas_req <= 1'b1;
      @(posedge ref_clk);
      meas_req <= 1'b0;
      repeat (40) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("mid busy", 1'b1, busy_ff) // command mode start
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      `CHK("rst2 busy", 1'b0, busy_ff) // mid-run reset
      `CHK("rst2 sleep", 1'b1, sleep_ff) // mid-run reset
      `CHK("rst2 cfg", 16'h0000, front_end_config_word) // mid-run reset
      `CHK("rst2 bridge", 16'h0000, bridge_raw_ff) // mid-run reset
      end_sim();
   end
endmodule
